/* File: common/fds_pkg.sv */
// constants and types shared by the fieldbus cyclic slave and its testbench
package fds_pkg;

  // ---------------------------------------------------------------
  // link limits
  // ---------------------------------------------------------------
  localparam int MAX_USER_BYTES = 246;
  localparam logic [8:0] MAX_USER_CNT = 9'd246;
  localparam int MAX_STATIONS = 126;
  localparam logic [6:0] ADDR_MAX = 7'(MAX_STATIONS - 1);
  localparam logic [6:0] ADDR_BCAST = 7'h7F;
  localparam logic [8:0] PRM_MAX_BYTES = 9'd8;
  // bit rate codes 0..6: 9.6, 19.2, 93.75, 187.5, 500, 1500, 12000 kbit/s
  localparam logic [2:0] BAUD_CODE_MAX = 3'h6;
  localparam int RSP_WIDTH = 9;
  localparam int CFG_BYTES = 4;

  // ---------------------------------------------------------------
  // control byte of a global request
  // ---------------------------------------------------------------
  localparam int GC_MODE_LSB = 0;
  localparam int GC_SYNC_BIT = 2;
  localparam int GC_FREEZE_BIT = 3;
  localparam logic [1:0] GC_STOP = 2'h0;
  localparam logic [1:0] GC_CLEAR = 2'h1;
  localparam logic [1:0] GC_OPERATE = 2'h2;

  // ---------------------------------------------------------------
  // answer status byte
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_ACK = 8'h00;
  localparam logic [7:0] STAT_NOT_READY = 8'h01;
  localparam logic [7:0] STAT_REJ_ACCESS = 8'h02;
  localparam logic [7:0] STAT_REJ_UNSUP = 8'h03;
  localparam logic [7:0] STAT_REJ_LENGTH = 8'h04;
  localparam logic [7:0] STAT_CFG_FAULT = 8'h05;
  localparam logic [7:0] STAT_STOPPED = 8'h06;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RECV = 2'h1,
    ST_STATUS = 2'h3,
    ST_SEND = 2'h2
  } fds_state_t;

  typedef enum logic [1:0] {
    PH_WAIT_PRM = 2'h0,
    PH_WAIT_CFG = 2'h1,
    PH_DATA = 2'h3
  } fds_phase_t;

  typedef enum logic [1:0] {
    MD_CLEAR = 2'h0,
    MD_STOP = 2'h1,
    MD_OPERATE = 2'h3
  } fds_mode_t;

  typedef enum logic [3:0] {
    K_PARAM = 4'h0,
    K_CHK_CFG = 4'h1,
    K_XCHG = 4'h2,
    K_GLOBAL = 4'h3,
    K_SET_ADDR = 4'h4,
    K_ACYCLIC = 4'h5,
    K_SLAVE_XFER = 4'h6
  } fds_kind_t;

endpackage

/* File: rtl/fds_buf2.sv */
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module fds_buf2 #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic head_valid;
    logic [WIDTH-1:0] head;
    logic skid_valid;
    logic [WIDTH-1:0] skid;
  } fds_buf_t;

  fds_buf_t b_reg;
  fds_buf_t b_next;
  logic push;
  logic pop;

  assign in_ready = ~b_reg.skid_valid;
  assign out_valid = b_reg.head_valid;
  assign out_data = b_reg.head;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    b_next = b_reg;
    push = in_valid & ~b_reg.skid_valid;
    pop = b_reg.head_valid & out_ready;
    if (!b_reg.head_valid || pop) begin
      if (b_reg.skid_valid) begin
        // refill from the skid entry; no push possible this cycle
        b_next.head = b_reg.skid;
        b_next.head_valid = 1'b1;
        b_next.skid_valid = 1'b0;
      end else begin
        b_next.head_valid = push;
        if (push) begin
          b_next.head = in_data;
        end
      end
    end else if (push) begin
      b_next.skid = in_data;
      b_next.skid_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

  property p_no_loss;
    @(posedge clk) disable iff (rst)
    (b_reg.head_valid && b_reg.skid_valid && !out_ready) |=> (b_reg.head_valid && b_reg.skid_valid);
  endproperty
  a_no_loss : assert property (p_no_loss)
    else $error("buffer dropped an entry under stall");

endmodule

/* File: rtl/fds_slave_top.sv */
// cyclic-exchange slave: startup order, operate/clear/stop and service filter
`timescale 1ns/1ps
module fds_slave_top #(
  // device type byte expected in the configuration; value is arbitrary
  parameter logic [7:0] DEVICE_TYPE = 8'h5A
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // local setup, read once after reset
  input wire logic [6:0] STATION_ADDR,
  input wire logic [2:0] BAUD_SEL,
  // local configuration
  input wire logic [7:0] CFG_FORMAT,
  input wire logic [7:0] IN_LEN,
  input wire logic [7:0] OUT_LEN,
  // decoded request bytes
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [3:0] REQ_KIND,
  input wire logic [6:0] REQ_SRC,
  input wire logic [6:0] REQ_DST,
  input wire logic [7:0] REQ_DATA,
  input wire logic REQ_LAST,
  // answer bytes
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output logic [7:0] RSP_DATA,
  output logic RSP_LAST,
  // application input image
  input wire logic APP_IN_WE,
  input wire logic [7:0] APP_IN_IDX,
  input wire logic [7:0] APP_IN_DATA,
  // application output image
  input wire logic [7:0] APP_OUT_IDX,
  output logic [7:0] APP_OUT_DATA,
  output logic APP_OUT_SAFE,
  output logic APP_OUT_UPDATE,
  output logic [7:0] APP_PARAM,
  // link status
  output logic [2:0] BAUD_CODE,
  output logic LINK_FAULT
);

  typedef struct packed {
    fds_pkg::fds_state_t state;
    fds_pkg::fds_phase_t phase;
    fds_pkg::fds_mode_t mode;
    fds_pkg::fds_kind_t kind;
    logic init;
    logic [6:0] own_addr;
    logic addr_ok;
    logic [2:0] baud;
    logic [6:0] master;
    logic [7:0] prm;
    logic [7:0] in_len;
    logic [7:0] out_len;
    logic bank;
    logic [8:0] cnt;
    logic [7:0] b0;
    logic cfg_bad;
    logic [7:0] status;
    logic req_ready;
    logic safe;
    logic upd;
  } fds_ctl_t;

  localparam fds_ctl_t CTL_RESET = '{
    state: fds_pkg::ST_IDLE,
    phase: fds_pkg::PH_WAIT_PRM,
    mode: fds_pkg::MD_CLEAR,
    kind: fds_pkg::K_PARAM,
    safe: 1'b1,
    default: '0
  };

  fds_ctl_t s_reg;
  fds_ctl_t s_next;

  // output image in two banks: writes land in the idle bank and a good frame in operate
  // flips the bank, so a rejected frame never disturbs the applied outputs
  logic [7:0] out_mem [2][fds_pkg::MAX_USER_BYTES];
  logic [7:0] in_mem [fds_pkg::MAX_USER_BYTES];
  logic [7:0] app_out_reg;

  logic rx;
  logic ev;
  logic first;
  logic [8:0] total;
  logic [7:0] b0_eff;
  logic cfg_bad_eff;
  logic [7:0] cfg_exp;
  logic to_me;
  logic from_master;
  logic respond;
  fds_pkg::fds_kind_t kind_in;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [8:0] buf_in_data;
  logic [8:0] buf_out_data;
  logic rsp_last_bit;

  // ---------------------------------------------------------------
  // request decode helpers
  // ---------------------------------------------------------------
  assign kind_in = fds_pkg::fds_kind_t'(REQ_KIND);
  assign rx = (s_reg.state == fds_pkg::ST_RECV) & REQ_VALID & s_reg.req_ready;
  assign ev = rx & REQ_LAST;
  assign first = (s_reg.cnt == 9'd0);
  assign total = s_reg.cnt + 9'd1;
  assign b0_eff = first ? REQ_DATA : s_reg.b0;
  assign to_me = s_reg.addr_ok & (REQ_DST == s_reg.own_addr);
  assign from_master = (s_reg.phase != fds_pkg::PH_WAIT_PRM) & (REQ_SRC == s_reg.master);

  always_comb begin
    unique case (s_reg.cnt[1:0])
      2'h0: cfg_exp = DEVICE_TYPE;
      2'h1: cfg_exp = CFG_FORMAT;
      2'h2: cfg_exp = IN_LEN;
      2'h3: cfg_exp = OUT_LEN;
    endcase
  end

  // device type, format and both lengths must all agree
  assign cfg_bad_eff = s_reg.cfg_bad
    | ((s_reg.cnt < 9'(fds_pkg::CFG_BYTES)) & (REQ_DATA != cfg_exp))
    | (9'(IN_LEN) > fds_pkg::MAX_USER_CNT) | (9'(OUT_LEN) > fds_pkg::MAX_USER_CNT);

  // ---------------------------------------------------------------
  // answer path
  // ---------------------------------------------------------------
  assign rsp_last_bit = (s_reg.state == fds_pkg::ST_STATUS)
    ? !((s_reg.status == fds_pkg::STAT_ACK) && (s_reg.kind == fds_pkg::K_XCHG)
        && (s_reg.in_len != 8'h00))
    : (s_reg.cnt == 9'(s_reg.in_len) - 9'd1);
  assign buf_in_valid = (s_reg.state == fds_pkg::ST_STATUS) | (s_reg.state == fds_pkg::ST_SEND);
  assign buf_in_data = {rsp_last_bit,
    (s_reg.state == fds_pkg::ST_STATUS) ? s_reg.status : in_mem[s_reg.cnt[7:0]]};

  fds_buf2 #(
    .WIDTH(fds_pkg::RSP_WIDTH)
  ) u_rsp_buf (
    .clk(CLK),
    .rst(RST),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(RSP_VALID),
    .out_ready(RSP_READY),
    .out_data(buf_out_data)
  );

  assign RSP_DATA = buf_out_data[7:0];
  assign RSP_LAST = buf_out_data[8];

  // ---------------------------------------------------------------
  // control next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.upd = 1'b0;
    respond = 1'b0;
    unique case (s_reg.state)
      fds_pkg::ST_IDLE: begin
        // address and bit rate are local and caught once
        s_next.init = 1'b1;
        s_next.own_addr = STATION_ADDR;
        s_next.baud = BAUD_SEL;
        s_next.addr_ok = (STATION_ADDR <= fds_pkg::ADDR_MAX)
          && (BAUD_SEL <= fds_pkg::BAUD_CODE_MAX);
        s_next.state = fds_pkg::ST_RECV;
      end
      fds_pkg::ST_RECV: begin
        if (rx) begin
          if (first) begin
            s_next.b0 = REQ_DATA;
          end
          s_next.cfg_bad = cfg_bad_eff;
          if (s_reg.cnt <= fds_pkg::MAX_USER_CNT) begin
            s_next.cnt = total;
          end
        end
        if (ev) begin
          s_next.cnt = 9'd0;
          s_next.cfg_bad = 1'b0;
          s_next.kind = kind_in;
          respond = to_me;
          case (kind_in)
            fds_pkg::K_PARAM: begin
              if (s_reg.phase != fds_pkg::PH_WAIT_PRM && !from_master) begin
                s_next.status = fds_pkg::STAT_REJ_ACCESS;
              end else if (total > fds_pkg::PRM_MAX_BYTES) begin
                s_next.status = fds_pkg::STAT_REJ_LENGTH;
              end else if (to_me) begin
                // fresh parameters apply even while exchanging
                s_next.status = fds_pkg::STAT_ACK;
                s_next.prm = b0_eff;
                s_next.master = REQ_SRC;
                if (s_reg.phase == fds_pkg::PH_WAIT_PRM) begin
                  s_next.phase = fds_pkg::PH_WAIT_CFG;
                end
              end
            end
            fds_pkg::K_CHK_CFG: begin
              if (s_reg.phase == fds_pkg::PH_WAIT_PRM) begin
                s_next.status = fds_pkg::STAT_NOT_READY;
              end else if (!from_master) begin
                s_next.status = fds_pkg::STAT_REJ_ACCESS;
              end else if (cfg_bad_eff || total != 9'(fds_pkg::CFG_BYTES)) begin
                s_next.status = fds_pkg::STAT_CFG_FAULT;
                if (to_me) begin
                  s_next.phase = fds_pkg::PH_WAIT_PRM;
                end
              end else if (to_me) begin
                s_next.status = fds_pkg::STAT_ACK;
                s_next.phase = fds_pkg::PH_DATA;
                s_next.in_len = IN_LEN;
                s_next.out_len = OUT_LEN;
              end
            end
            fds_pkg::K_XCHG: begin
              if (s_reg.phase != fds_pkg::PH_DATA) begin
                s_next.status = fds_pkg::STAT_NOT_READY;
              end else if (!from_master) begin
                s_next.status = fds_pkg::STAT_REJ_ACCESS;
              end else if (s_reg.mode == fds_pkg::MD_STOP) begin
                s_next.status = fds_pkg::STAT_STOPPED;
              end else if (s_reg.cnt > fds_pkg::MAX_USER_CNT
                  || total != ((s_reg.out_len == 8'h00) ? 9'd1 : 9'(s_reg.out_len))) begin
                s_next.status = fds_pkg::STAT_REJ_LENGTH;
              end else if (to_me) begin
                s_next.status = fds_pkg::STAT_ACK;
                if (s_reg.mode == fds_pkg::MD_OPERATE && s_reg.out_len != 8'h00) begin
                  s_next.bank = ~s_reg.bank;
                  s_next.upd = 1'b1;
                end
              end
            end
            fds_pkg::K_GLOBAL: begin
              if (!from_master) begin
                s_next.status = fds_pkg::STAT_REJ_ACCESS;
              end else if (b0_eff[fds_pkg::GC_SYNC_BIT] || b0_eff[fds_pkg::GC_FREEZE_BIT]
                  || b0_eff[fds_pkg::GC_MODE_LSB +: 2] == 2'h3) begin
                s_next.status = fds_pkg::STAT_REJ_UNSUP;
              end else if (to_me || (s_reg.addr_ok && REQ_DST == fds_pkg::ADDR_BCAST)) begin
                s_next.status = fds_pkg::STAT_ACK;
                unique case (b0_eff[fds_pkg::GC_MODE_LSB +: 2])
                  fds_pkg::GC_STOP: s_next.mode = fds_pkg::MD_STOP;
                  fds_pkg::GC_CLEAR: s_next.mode = fds_pkg::MD_CLEAR;
                  default: s_next.mode = fds_pkg::MD_OPERATE;
                endcase
              end
            end
            default: begin
              // address setting, acyclic and slave-to-slave
              s_next.status = fds_pkg::STAT_REJ_UNSUP;
            end
          endcase
          if (respond) begin
            s_next.state = fds_pkg::ST_STATUS;
          end
        end
      end
      fds_pkg::ST_STATUS: begin
        if (buf_in_ready) begin
          s_next.cnt = 9'd0;
          s_next.state = rsp_last_bit ? fds_pkg::ST_RECV : fds_pkg::ST_SEND;
        end
      end
      fds_pkg::ST_SEND: begin
        // inputs go out in operate and in clear alike
        if (buf_in_ready) begin
          s_next.cnt = s_reg.cnt + 9'd1;
          if (rsp_last_bit) begin
            s_next.cnt = 9'd0;
            s_next.state = fds_pkg::ST_RECV;
          end
        end
      end
    endcase
    // outputs held safe unless set up and operating
    s_next.safe = (s_next.phase != fds_pkg::PH_DATA) || (s_next.mode != fds_pkg::MD_OPERATE);
    // the byte port only opens once setup is caught and the link is idle
    s_next.req_ready = s_next.init && (s_next.state == fds_pkg::ST_RECV)
      && !(ev && respond);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_reg <= CTL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // images
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (rx && kind_in == fds_pkg::K_XCHG && s_reg.cnt < fds_pkg::MAX_USER_CNT) begin
      out_mem[~s_reg.bank][s_reg.cnt[7:0]] <= REQ_DATA;
    end
    if (APP_IN_WE && 9'(APP_IN_IDX) < fds_pkg::MAX_USER_CNT) begin
      in_mem[APP_IN_IDX] <= APP_IN_DATA;
    end
  end

  // out-of-range index reads zero rather than wrapping into the other bank
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      app_out_reg <= 8'h00;
    end else if (9'(APP_OUT_IDX) < fds_pkg::MAX_USER_CNT) begin
      app_out_reg <= out_mem[s_reg.bank][APP_OUT_IDX];
    end else begin
      app_out_reg <= 8'h00;
    end
  end

  assign APP_OUT_DATA = app_out_reg;
  assign APP_OUT_SAFE = s_reg.safe;
  assign APP_OUT_UPDATE = s_reg.upd;
  assign APP_PARAM = s_reg.prm;
  assign REQ_READY = s_reg.req_ready;
  assign BAUD_CODE = s_reg.baud;
  assign LINK_FAULT = s_reg.init & ~s_reg.addr_ok;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_foreign_write;
    ev && kind_in == fds_pkg::K_XCHG && REQ_SRC != s_reg.master;
  endsequence

  sequence s_bad_cfg;
    ev && to_me && kind_in == fds_pkg::K_CHK_CFG && s_reg.phase == fds_pkg::PH_WAIT_CFG
      && REQ_SRC == s_reg.master
      && (cfg_bad_eff || total != 9'(fds_pkg::CFG_BYTES));
  endsequence

  property p_safe_until_set_up;
    (s_reg.phase != fds_pkg::PH_DATA) |-> (APP_OUT_SAFE && !APP_OUT_UPDATE);
  endproperty
  a_safe_until_set_up : assert property (p_safe_until_set_up)
    else $error("outputs not safe before data phase");

  property p_update_only_operate;
    APP_OUT_UPDATE |-> (s_reg.mode == fds_pkg::MD_OPERATE && !APP_OUT_SAFE);
  endproperty
  a_update_only_operate : assert property (p_update_only_operate)
    else $error("outputs applied outside operate");

  property p_phase_order;
    (s_reg.phase == fds_pkg::PH_DATA && $past(s_reg.phase) != fds_pkg::PH_DATA)
      |-> $past(s_reg.phase) == fds_pkg::PH_WAIT_CFG;
  endproperty
  a_phase_order : assert property (p_phase_order)
    else $error("data phase entered out of order");

  property p_bad_cfg_blocks;
    s_bad_cfg |=> (s_reg.phase == fds_pkg::PH_WAIT_PRM && s_reg.status == fds_pkg::STAT_CFG_FAULT);
  endproperty
  a_bad_cfg_blocks : assert property (p_bad_cfg_blocks)
    else $error("configuration mismatch not refused");

  property p_foreign_write;
    s_foreign_write |=> (!APP_OUT_UPDATE && $stable(s_reg.bank));
  endproperty
  a_foreign_write : assert property (p_foreign_write)
    else $error("foreign master changed outputs");

  property p_no_sync_freeze;
    (ev && kind_in == fds_pkg::K_GLOBAL
      && (b0_eff[fds_pkg::GC_SYNC_BIT] || b0_eff[fds_pkg::GC_FREEZE_BIT]))
      |=> $stable(s_reg.mode);
  endproperty
  a_no_sync_freeze : assert property (p_no_sync_freeze)
    else $error("sync or freeze changed the mode");

  property p_set_addr_refused;
    (ev && to_me && kind_in == fds_pkg::K_SET_ADDR)
      |=> (s_reg.status == fds_pkg::STAT_REJ_UNSUP && $stable(s_reg.own_addr));
  endproperty
  a_set_addr_refused : assert property (p_set_addr_refused)
    else $error("address request not refused");

  property p_oversize_refused;
    (ev && kind_in == fds_pkg::K_XCHG && s_reg.cnt >= fds_pkg::MAX_USER_CNT) |=> !APP_OUT_UPDATE;
  endproperty
  a_oversize_refused : assert property (p_oversize_refused)
    else $error("oversize frame applied");

  property p_rate_fixed;
    $past(s_reg.init) |-> $stable(BAUD_CODE);
  endproperty
  a_rate_fixed : assert property (p_rate_fixed)
    else $error("bit rate changed in operation");

  property p_every_request_answered;
    (ev && to_me) |=> s_reg.state == fds_pkg::ST_STATUS ##[1:300] RSP_VALID;
  endproperty
  a_every_request_answered : assert property (p_every_request_answered)
    else $error("addressed request left unanswered");

endmodule

/* File: dv/fds_mst.sv */
// master model: sends request frames, gathers answers
`timescale 1ns/1ps
module fds_mst (
  // clock
  input wire logic clk,
  // requests
  output logic req_valid,
  input wire logic req_ready,
  output logic [3:0] req_kind,
  output logic [6:0] req_src,
  output logic [6:0] req_dst,
  output logic [7:0] req_data,
  output logic req_last,
  // answers
  output logic rsp_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic slow = 1'b0;
  logic [7:0] ans[$];
  initial begin
    req_valid = 1'b0;
    req_last = 1'b0;
    req_kind = 4'h0;
    req_src = 7'h00;
    req_dst = 7'h00;
    req_data = 8'h00;
    rsp_ready = 1'b1;
  end
  // stall every other cycle when slow
  always @(posedge clk) begin
    rsp_ready <= #1 slow ? ~rsp_ready : 1'b1;
  end
  // frame out whole, answer in
  // one slave polled in the same order each bus cycle
  // a frame and its answer fit well inside a controller cycle
  // the 400-cycle limit is the master's watchdog on the exchange
  task automatic frame(input logic [3:0] k, input logic [6:0] s, input logic [6:0] d,
    input int n, input logic [31:0] p, output logic [7:0] st);
    int t;
    logic done;
    ans.delete();
    st = 8'hFF;
    req_kind = k;
    req_src = s;
    req_dst = d;
    for (int i = 0; i < n; i++) begin
      req_valid = 1'b1;
      req_data = p[8*(i%4) +: 8];
      req_last = (i == n - 1);
      t = 0;
      @(posedge clk);
      while (req_ready !== 1'b1 && t < 400) begin
        @(posedge clk);
        t++;
      end
      #1;
    end
    req_valid = 1'b0;
    req_last = 1'b0;
    // released data never shows the last byte
    req_data = ~req_data;
    done = (d == 7'h7F);
    t = 0;
    while (!done && t < 400) begin
      @(posedge clk);
      t++;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        if (st === 8'hFF) st = rsp_data;
        else ans.push_back(rsp_data);
        done = (rsp_last === 1'b1);
      end
    end
    #1;
  endtask
endmodule

/* File: dv/test_fieldbus_dp_slave_cyclic_exchange.sv */
// self-checking bench for the cyclic slave
`timescale 1ns/1ps
module test_fieldbus_dp_slave_cyclic_exchange;
  // ----
  // signals
  // ----
  localparam logic [31:0] CFG = 32'h0101115A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] upd = 8'h00;
  logic [7:0] st, in_data = 8'h00, idx = 8'h00;
  logic in_we = 1'b0;
  logic rv, rr, rl, pv, pr, pl, safe, updp, fault;
  logic [3:0] rk;
  logic [6:0] rs, rd;
  logic [7:0] rdat, pdat, odat, prm;
  logic [2:0] baud;
  always #2.5 clk = ~clk;
  fds_slave_top fds_slave_top_inst (.CLK(clk), .RST(rst), .STATION_ADDR(7'h05),
    .BAUD_SEL(3'h3), .CFG_FORMAT(8'h11), .IN_LEN(8'h01), .OUT_LEN(8'h01),
    .REQ_VALID(rv), .REQ_READY(rr), .REQ_KIND(rk), .REQ_SRC(rs), .REQ_DST(rd),
    .REQ_DATA(rdat), .REQ_LAST(rl), .RSP_VALID(pv), .RSP_READY(pr),
    .RSP_DATA(pdat), .RSP_LAST(pl), .APP_IN_WE(in_we), .APP_IN_IDX(idx),
    .APP_IN_DATA(in_data), .APP_OUT_IDX(idx), .APP_OUT_DATA(odat),
    .APP_OUT_SAFE(safe), .APP_OUT_UPDATE(updp), .APP_PARAM(prm),
    .BAUD_CODE(baud), .LINK_FAULT(fault));
  fds_mst fds_mst_inst (.clk(clk), .req_valid(rv), .req_ready(rr), .req_kind(rk),
    .req_src(rs), .req_dst(rd), .req_data(rdat), .req_last(rl), .rsp_ready(pr),
    .rsp_valid(pv), .rsp_data(pdat), .rsp_last(pl));
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic fr(input logic [3:0] k, input logic [6:0] s, input int n,
    input logic [31:0] p);
    fds_mst_inst.frame(k, s, 7'h05, n, p, st);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (updp === 1'b1) upd <= upd + 8'h01;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  // ----
  // scenarios
  // ----
  task automatic t_start();
    chk("baud", 8'h03, {5'h00, baud});
    chk("fault", 8'h00, {7'h00, fault});
    fr(fds_pkg::K_XCHG, 7'h02, 1, 32'h0);
    chk("status", fds_pkg::STAT_NOT_READY, st);
    fr(fds_pkg::K_CHK_CFG, 7'h02, 4, CFG);
    chk("status", fds_pkg::STAT_NOT_READY, st);
    chk("safe", 8'h01, {7'h00, safe});
    $display("test start done");
  endtask
  task automatic t_setup();
    fr(fds_pkg::K_PARAM, 7'h02, 1, 32'h3C);
    chk("status", fds_pkg::STAT_ACK, st);
    chk("param", 8'h3C, prm);
    fr(fds_pkg::K_CHK_CFG, 7'h02, 4, CFG ^ 32'h100);
    chk("status", fds_pkg::STAT_CFG_FAULT, st);
    fr(fds_pkg::K_CHK_CFG, 7'h02, 4, CFG);
    chk("status", fds_pkg::STAT_NOT_READY, st);
    fr(fds_pkg::K_PARAM, 7'h02, 1, 32'h3C);
    fr(fds_pkg::K_CHK_CFG, 7'h02, 4, CFG);
    chk("status", fds_pkg::STAT_ACK, st);
    $display("test setup done");
  endtask
  task automatic t_clear();
    in_we = 1'b1;
    in_data = 8'hC3;
    @(posedge clk);
    #1;
    in_we = 1'b0;
    // receiver stalls to exercise the answer buffer
    fds_mst_inst.slow = 1'b1;
    fr(fds_pkg::K_XCHG, 7'h02, 1, 32'hA5);
    fds_mst_inst.slow = 1'b0;
    chk("status", fds_pkg::STAT_ACK, st);
    chk("answer length", 8'h01, 8'(fds_mst_inst.ans.size()));
    chk("input", 8'hC3, fds_mst_inst.ans[0]);
    chk("updates", 8'h00, upd);
    chk("safe", 8'h01, {7'h00, safe});
    $display("test clear done");
  endtask
  task automatic t_operate();
    fr(fds_pkg::K_GLOBAL, 7'h02, 1, {30'h0, fds_pkg::GC_OPERATE});
    chk("status", fds_pkg::STAT_ACK, st);
    fr(fds_pkg::K_XCHG, 7'h02, 1, 32'hA5);
    chk("input", 8'hC3, fds_mst_inst.ans[0]);
    repeat (3) @(posedge clk);
    #1;
    chk("updates", 8'h01, upd);
    chk("output", 8'hA5, odat);
    chk("safe", 8'h00, {7'h00, safe});
    fr(fds_pkg::K_XCHG, 7'h09, 1, 32'h5A);
    chk("status", fds_pkg::STAT_REJ_ACCESS, st);
    repeat (3) @(posedge clk);
    #1;
    chk("output", 8'hA5, odat);
    $display("test operate done");
  endtask
  task automatic t_refuse();
    for (int k = 4; k < 7; k++) begin
      fr(k[3:0], 7'h02, 1, 32'h0);
      chk("status", fds_pkg::STAT_REJ_UNSUP, st);
    end
    fr(fds_pkg::K_GLOBAL, 7'h02, 1, 32'h06);
    chk("status", fds_pkg::STAT_REJ_UNSUP, st);
    fr(fds_pkg::K_GLOBAL, 7'h02, 1, 32'h0A);
    chk("status", fds_pkg::STAT_REJ_UNSUP, st);
    fr(fds_pkg::K_GLOBAL, 7'h02, 1, 32'h03);
    chk("status", fds_pkg::STAT_REJ_UNSUP, st);
    fr(fds_pkg::K_XCHG, 7'h02, 247, 32'h0);
    chk("status", fds_pkg::STAT_REJ_LENGTH, st);
    $display("test refuse done");
  endtask
  task automatic t_reparam();
    fr(fds_pkg::K_PARAM, 7'h02, 1, 32'h66);
    chk("status", fds_pkg::STAT_ACK, st);
    chk("param", 8'h66, prm);
    fr(fds_pkg::K_PARAM, 7'h09, 1, 32'h11);
    chk("status", fds_pkg::STAT_REJ_ACCESS, st);
    // stopping takes this slave out of cyclic exchange
    fr(fds_pkg::K_GLOBAL, 7'h02, 1, {30'h0, fds_pkg::GC_STOP});
    fr(fds_pkg::K_XCHG, 7'h02, 1, 32'h0);
    chk("status", fds_pkg::STAT_STOPPED, st);
    $display("test reparam and stop done");
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    t_start();
    t_setup();
    t_clear();
    t_operate();
    t_refuse();
    t_reparam();
    results();
  end
endmodule
